// file: interrupt_vector_shadow_map.sv
// Interrupt request map, priority selection and shadow set choice.
// Assumes an APB master on pclk and on-chip sources on the same clock.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// RQ1 - Level 3 shadow field at bits 15:12; codes 0-7 pick set 0-7.
// RQ2 - Level 2 shadow field at bits 11:8; codes 0-7 pick set 0-7.
// RQ3 - Level 1 shadow field at bits 7:4; codes 0-7 pick set 0-7.
// RQ4 - A field code with top bit set is reserved and gives set 0.
// RQ5 - Single vector uses a shadow set only when bit 0 is one.
// RQ6 - Shadow select bits 3:1 always read as zero.
// RQ7 - Per-level fields are ignored while multi-vector enable is zero.
// RQ8 - Request n: flag/enable bit n mod 32; priority byte n mod 4.
// RQ9 - Requests 106, 107: bus protection and crypto, persistent.
// RQ10 - Requests 115-117: two-wire collision, target, controller, persistent.
// RQ11 - Requests 118-127: port change A to K without I, persistent.
// RQ12 - 128, 129 parallel port persistent; 130, 131 comparators follow source.
// RQ13 - Persistent flags hold until cleared; others follow their source.
module interrupt_vector_shadow_map
    import ivsm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [REQ_COUNT-1:0] source,
    output logic vector_valid,
    output logic [7:0] vector_number,
    output logic [2:0] vector_level,
    output logic [1:0] vector_sub,
    output logic [2:0] vector_shadow_set,
    output logic vector_uses_shadow,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [31:0] interrupt_control_register;
    logic [31:0] priority_shadow_select;
    logic [EVENT_W-1:0] event_status;
    logic [EVENT_W-1:0] event_mask;
    logic [REQ_COUNT-1:0] enable;
    logic [31:0] prio_reg [PRIO_REG_COUNT];
    logic [REQ_COUNT-1:0] flag;
    logic [REQ_COUNT-1:0] flag_clear;
    logic multi_vector_enable;

    logic wr_en;
    logic rd_en;
    logic mapped;
    logic prio_hit;
    logic [3:0] prio_idx;
    logic [31:0] wmask;
    logic [31:0] rd_word;

    assign multi_vector_enable = interrupt_control_register[MULTI_VECTOR_ENABLE_BIT];

    // Byte enables widened to a bit mask
    function automatic logic [31:0] strobe_mask(input logic [3:0] s);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b*BYTE_W +: BYTE_W] = {BYTE_W{s[b]}};
        end
        return m;
    endfunction : strobe_mask

    // Masked merge of write data into a register
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] data, input logic [31:0] m);
        return (old & ~m) | (data & m);
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////
    // APB decode; zero wait states
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign wmask = strobe_mask(pstrb);
    assign prio_hit = (paddr >= OFS_PRIO_BASE) &&
        (paddr < OFS_PRIO_BASE + 12'(PRIO_REG_COUNT * 4)) &&
        (paddr[1:0] == 2'h0);
    assign prio_idx = 4'((paddr - OFS_PRIO_BASE) >> 2);
    assign pready = 1'b1;

    always_comb begin
        mapped = 1'b1;
        rd_word = RESET_WORD;
        case (paddr)
            OFS_CONTROL: rd_word = interrupt_control_register;
            OFS_SHADOW: rd_word = priority_shadow_select & SHADOW_WRITE_MASK; // RQ6
            OFS_STATUS: rd_word = 32'(event_status);
            OFS_MASK: rd_word = 32'(event_mask);
            OFS_FLAG_FOUR: rd_word = flag[0 +: WORD_W]; // RQ8
            OFS_FLAG_FIVE: rd_word = flag[WORD_W +: WORD_W]; // RQ8
            OFS_ENABLE_FOUR: rd_word = enable[0 +: WORD_W];
            OFS_ENABLE_FIVE: rd_word = enable[WORD_W +: WORD_W];
            default: begin
                if (prio_hit) begin
                    rd_word = prio_reg[prio_idx];
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    assign pslverr = psel & penable & ~mapped;

    // Read data held in a flop, loaded in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= RESET_WORD;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and shadow select registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_control_register <= RESET_WORD;
            priority_shadow_select <= RESET_WORD;
        end else if (wr_en) begin
            if (paddr == OFS_CONTROL) begin
                interrupt_control_register <= merge(interrupt_control_register,
                    pwdata, wmask & CONTROL_WRITE_MASK);
            end
            if (paddr == OFS_SHADOW) begin
                priority_shadow_select <= merge(priority_shadow_select,
                    pwdata, wmask & SHADOW_WRITE_MASK); // RQ6
            end
        end
    end

    // Enable registers, bit n mod 32 of word n/32
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable <= '0;
        end else if (wr_en) begin
            if (paddr == OFS_ENABLE_FOUR) begin
                enable[0 +: WORD_W] <= merge(enable[0 +: WORD_W], pwdata,
                    wmask); // RQ8
            end
            if (paddr == OFS_ENABLE_FIVE) begin
                enable[WORD_W +: WORD_W] <= merge(enable[WORD_W +: WORD_W],
                    pwdata, wmask); // RQ8
            end
        end
    end

    // Priority registers, five live bits in each byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < PRIO_REG_COUNT; i++) begin
                prio_reg[i] <= RESET_WORD;
            end
        end else if (wr_en && prio_hit) begin
            prio_reg[prio_idx] <= merge(prio_reg[prio_idx], pwdata,
                wmask & {4{PRIO_BYTE_MASK}}); // RQ8
        end
    end

    // Write-one clear of flag words
    always_comb begin
        flag_clear = '0;
        if (wr_en && paddr == OFS_FLAG_FOUR) begin
            flag_clear[0 +: WORD_W] = pwdata & wmask;
        end
        if (wr_en && paddr == OFS_FLAG_FIVE) begin
            flag_clear[WORD_W +: WORD_W] = pwdata & wmask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags; comparators 130, 131 follow, all others persist
    irq_flag_bank #(
        .N(REQ_COUNT),
        .PERSIST(PERSIST_MASK) // RQ9 RQ10 RQ11 RQ12
    ) u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .source(source),
        .clear(flag_clear),
        .flag(flag)
    );

    ////////////////////////////////////////////////////////////////////////
    // Priority selection across pending enabled requests
    function automatic logic [2:0] req_level(input int n);
        return prio_reg[n/4 - PRIO_FIRST_INDEX + REQ_BASE/4]
            [(n%4)*BYTE_W + PRIO_LSB +: PRIO_W]; // RQ8
    endfunction : req_level

    function automatic logic [1:0] req_sub(input int n);
        return prio_reg[n/4 - PRIO_FIRST_INDEX + REQ_BASE/4]
            [(n%4)*BYTE_W +: SUB_W]; // RQ8
    endfunction : req_sub

    logic next_valid;
    logic [7:0] next_number;
    logic [2:0] next_level;
    logic [1:0] next_sub;
    logic [2:0] next_set;
    logic next_uses;

    always_comb begin
        next_valid = 1'b0;
        next_number = '0;
        next_level = LEVEL_OFF;
        next_sub = '0;
        for (int i = 0; i < REQ_COUNT; i++) begin
            if (flag[i] && enable[i] && req_level(i) != LEVEL_OFF &&
                (!next_valid || req_level(i) > next_level ||
                (req_level(i) == next_level && req_sub(i) > next_sub))) begin
                next_valid = 1'b1;
                next_number = 8'(REQ_BASE + i);
                next_level = req_level(i);
                next_sub = req_sub(i);
            end
        end
    end

    shadow_resolver u_shadow (
        .shadow_word(priority_shadow_select),
        .multi_vector_enable(multi_vector_enable),
        .level(next_level),
        .shadow_set(next_set),
        .uses_shadow(next_uses)
    );

    // Vector towards the core; single vector mode presents number 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_valid <= 1'b0;
            vector_number <= '0;
            vector_level <= LEVEL_OFF;
            vector_sub <= '0;
            vector_shadow_set <= SET_ZERO;
            vector_uses_shadow <= 1'b0;
        end else begin
            vector_valid <= next_valid;
            vector_number <= multi_vector_enable ? next_number : 8'h00;
            vector_level <= next_level;
            vector_sub <= next_sub;
            vector_shadow_set <= next_set; // RQ1 RQ2 RQ3 RQ4 RQ7
            vector_uses_shadow <= next_uses; // RQ5
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Block events, status, mask and interrupt line
    logic [EVENT_W-1:0] event_set;
    logic [EVENT_W-1:0] event_clear;

    always_comb begin
        event_set = '0;
        event_set[EV_RESERVED_CODE] = wr_en && paddr == OFS_SHADOW &&
            (pwdata[L3_FIELD_LSB+FIELD_W-1] || pwdata[L2_FIELD_LSB+FIELD_W-1]
            || pwdata[L1_FIELD_LSB+FIELD_W-1]);
        event_set[EV_NEW_VECTOR] = next_valid && (!vector_valid ||
            (multi_vector_enable ? next_number : 8'h00) != vector_number);
        event_clear = (wr_en && paddr == OFS_STATUS) ?
            pwdata[EVENT_W-1:0] : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_status <= '0;
            event_mask <= '0;
        end else begin
            event_status <= event_set | (event_status & ~event_clear);
            if (wr_en && paddr == OFS_MASK) begin
                event_mask <= pwdata[EVENT_W-1:0];
            end
        end
    end

    assign irq = |(event_status & event_mask);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    level3_set_a: assert property ( // RQ1
        multi_vector_enable && next_level == 3'h3 &&
        !priority_shadow_select[15] |=>
        vector_shadow_set == $past(priority_shadow_select[14:12]))
        else $error("level 3 shadow set mismatch");
    level2_set_a: assert property ( // RQ2
        multi_vector_enable && next_level == 3'h2 &&
        !priority_shadow_select[11] |=>
        vector_shadow_set == $past(priority_shadow_select[10:8]))
        else $error("level 2 shadow set mismatch");
    level1_set_a: assert property ( // RQ3
        multi_vector_enable && next_level == 3'h1 &&
        !priority_shadow_select[7] |=>
        vector_shadow_set == $past(priority_shadow_select[6:4]))
        else $error("level 1 shadow set mismatch");
    reserved_zero_a: assert property ( // RQ4
        multi_vector_enable && next_level == 3'h3 &&
        priority_shadow_select[15] |=> vector_shadow_set == 3'h0)
        else $error("reserved code did not give set 0");
    single_shadow_a: assert property ( // RQ5
        !multi_vector_enable |=>
        vector_uses_shadow == $past(priority_shadow_select[0]))
        else $error("single vector shadow use wrong");
    unimpl_read_a: assert property ( // RQ6
        psel && !penable && !pwrite && paddr == OFS_SHADOW |=>
        prdata[3:1] == 3'h0)
        else $error("shadow select bits 3:1 not zero");
    fields_ignored_a: assert property ( // RQ7
        !multi_vector_enable |=> vector_shadow_set == 3'h0 &&
        vector_number == 8'h00)
        else $error("fields used with multi-vector off");
    no_pend_idle_a: assert property ( // RQ8
        (flag & enable) == '0 |=> !vector_valid)
        else $error("vector without pending enabled request");
    comparator_follow_a: assert property ( // RQ12
        ##1 flag[REQ_COMPARATOR1-REQ_BASE] ==
        $past(source[REQ_COMPARATOR1-REQ_BASE]))
        else $error("comparator flag does not follow source");
    crypto_hold_a: assert property ( // RQ9
        flag[REQ_CRYPTO-REQ_BASE] && flag_clear[REQ_CRYPTO-REQ_BASE] == 1'b0
        |=> flag[REQ_CRYPTO-REQ_BASE])
        else $error("crypto flag lost without a clear");
    irq_level_a: assert property (
        ##1 irq == |($past(event_set | (event_status & ~event_clear)) &
        event_mask))
        else $error("interrupt line disagrees with status");

    cover_multi_c: cover property (multi_vector_enable ##1 vector_valid &&
        vector_uses_shadow);
    cover_single_c: cover property (!multi_vector_enable && vector_valid &&
        vector_uses_shadow);
    cover_clear_c: cover property (|flag_clear ##1 !vector_valid);

endmodule : interrupt_vector_shadow_map
`default_nettype wire

// file: ivsm_pkg.sv
// Constants shared by the interrupt vector and shadow map block.
// Assumes a 32-bit APB register bus and requests 96 to 159 on the sources.
package ivsm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus and register map
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_SHADOW = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    localparam logic [11:0] OFS_MASK = 12'h00C;
    localparam logic [11:0] OFS_FLAG_FOUR = 12'h010;
    localparam logic [11:0] OFS_FLAG_FIVE = 12'h014;
    localparam logic [11:0] OFS_ENABLE_FOUR = 12'h018;
    localparam logic [11:0] OFS_ENABLE_FIVE = 12'h01C;
    localparam logic [11:0] OFS_PRIO_BASE = 12'h040;
    localparam int PRIO_REG_COUNT = 16;
    localparam int PRIO_FIRST_INDEX = 24;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Control and shadow select fields
    localparam int MULTI_VECTOR_ENABLE_BIT = 12;
    localparam logic [31:0] CONTROL_WRITE_MASK = 32'h0000_1000;
    localparam logic [31:0] SHADOW_WRITE_MASK = 32'h0000_FFF1;
    localparam int FIELD_W = 4;
    localparam int L3_FIELD_LSB = 12;
    localparam int L2_FIELD_LSB = 8;
    localparam int L1_FIELD_LSB = 4;
    localparam int SS0_BIT = 0;
    localparam logic [2:0] SET_ZERO = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // Request numbering and priority byte layout
    localparam int REQ_BASE = 96;
    localparam int REQ_COUNT = 64;
    localparam int WORD_W = 32;
    localparam int PRIO_W = 3;
    localparam int SUB_W = 2;
    localparam int PRIO_LSB = 2;
    localparam int BYTE_W = 8;
    localparam logic [7:0] PRIO_BYTE_MASK = 8'h1F;
    localparam logic [2:0] LEVEL_OFF = 3'h0;
    localparam logic [63:0] PERSIST_MASK = 64'hFFFF_FFF3_FFFF_FFFF;
    localparam int REQ_BUS_PROTECT = 106;
    localparam int REQ_CRYPTO = 107;
    localparam int REQ_TWI1_COLLISION = 115;
    localparam int REQ_TWI1_TARGET = 116;
    localparam int REQ_TWI1_CONTROLLER = 117;
    localparam int REQ_PORTA_CHANGE = 118;
    localparam int REQ_PORTK_CHANGE = 127;
    localparam int REQ_PARPORT = 128;
    localparam int REQ_PARPORT_ERROR = 129;
    localparam int REQ_COMPARATOR1 = 130;
    localparam int REQ_COMPARATOR2 = 131;

    ////////////////////////////////////////////////////////////////////////
    // Block events
    localparam int EVENT_W = 2;
    localparam int EV_RESERVED_CODE = 0;
    localparam int EV_NEW_VECTOR = 1;

endpackage : ivsm_pkg

// file: irq_flag_bank.sv
// Flag bits of one group of interrupt requests.
// Sources are on-chip logic on pclk; clears come as a write-one mask.
`timescale 1ns/10ps
`default_nettype none
module irq_flag_bank
    import ivsm_pkg::*;
#(
    parameter int N = REQ_COUNT,
    parameter logic [63:0] PERSIST = PERSIST_MASK
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [N-1:0] source,
    input wire logic [N-1:0] clear,
    output logic [N-1:0] flag
);

    // Refuse widths that the persistence mask cannot cover
    if (N < 1 || N > 64) begin : g_bad_width
        $error("irq_flag_bank: N out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky or following flags; a set beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (PERSIST[i]) begin
                    flag[i] <= source[i] | (flag[i] & ~clear[i]); // RQ13
                end else begin
                    flag[i] <= source[i]; // RQ13
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    persist_hold_a: assert property ( // RQ13
        flag[0] && !source[0] && !clear[0] |=> flag[0])
        else $error("persistent flag dropped without a clear");
    follow_src_a: assert property ( // RQ13
        ##1 (flag & ~PERSIST[N-1:0]) == ($past(source) & ~PERSIST[N-1:0]))
        else $error("non-persistent flag does not follow source");
    set_wins_a: assert property ( // RQ13
        source[0] && clear[0] |=> flag[0])
        else $error("clear beat a simultaneous set");

endmodule : irq_flag_bank
`default_nettype wire

// file: shadow_resolver.sv
// Picks the shadow register set for a priority level.
// Pure combinational; the caller registers the results.
`timescale 1ns/10ps
`default_nettype none
module shadow_resolver
    import ivsm_pkg::*;
(
    input wire logic [31:0] shadow_word,
    input wire logic multi_vector_enable,
    input wire logic [2:0] level,
    output logic [2:0] shadow_set,
    output logic uses_shadow
);

    // Reserved code falls back to set 0
    function automatic logic [2:0] field_set(input logic [3:0] code);
        return code[FIELD_W-1] ? SET_ZERO : code[2:0]; // RQ4
    endfunction : field_set

    logic [3:0] level3_shadow_field;
    logic [3:0] level2_shadow_field;
    logic [3:0] level1_shadow_field;
    logic single_vector_shadow_bit;

    assign level3_shadow_field = shadow_word[L3_FIELD_LSB +: FIELD_W]; // RQ1
    assign level2_shadow_field = shadow_word[L2_FIELD_LSB +: FIELD_W]; // RQ2
    assign level1_shadow_field = shadow_word[L1_FIELD_LSB +: FIELD_W]; // RQ3
    assign single_vector_shadow_bit = shadow_word[SS0_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Per-level fields only count in multi-vector mode
    always_comb begin
        shadow_set = SET_ZERO;
        uses_shadow = 1'b0;
        if (!multi_vector_enable) begin
            uses_shadow = single_vector_shadow_bit; // RQ5 RQ7
        end else begin
            case (level)
                3'h3: shadow_set = field_set(level3_shadow_field); // RQ1
                3'h2: shadow_set = field_set(level2_shadow_field); // RQ2
                3'h1: shadow_set = field_set(level1_shadow_field); // RQ3
                default: shadow_set = SET_ZERO;
            endcase
            uses_shadow = (shadow_set != SET_ZERO);
        end
    end

endmodule : shadow_resolver
`default_nettype wire

// file: ivsm_partner.sv
// Model of the on-chip peripherals that raise interrupt conditions.
// Assumes the bench asks for conditions to rise or fall on pclk.
`timescale 1ns/10ps
`default_nettype none
module ivsm_partner
    import ivsm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [REQ_COUNT-1:0] raise,
    input wire logic [REQ_COUNT-1:0] drop,
    output var logic [REQ_COUNT-1:0] source
);
    // Condition stays up until its peripheral drops it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source <= '0;
        end else begin
            source <= (source | raise) & ~drop;
        end
    end
endmodule : ivsm_partner
`default_nettype wire

// file: interrupt_vector_shadow_map_test.sv
// Self-checking bench for the vector and shadow map block.
// Assumes the APB slave answers with pready and the partner on pclk.
`timescale 1ns/10ps
`default_nettype none
module interrupt_vector_shadow_map_test;
    import ivsm_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, rd, w;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, last_err, vector_valid, vector_uses_shadow, irq;
    logic [REQ_COUNT-1:0] source, raise = '0, drop = '0;
    logic [7:0] vector_number;
    logic [2:0] vector_level, vector_shadow_set;
    logic [1:0] vector_sub, sub;
    int err_count = 0, cmp_count = 0;
    ////////////////////////////////////////////////////////////////////////
    // Clock, design and partner
    always #20 pclk = ~pclk;
    interrupt_vector_shadow_map i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .source(source), .vector_valid(vector_valid),
        .vector_number(vector_number), .vector_level(vector_level),
        .vector_sub(vector_sub), .vector_shadow_set(vector_shadow_set),
        .vector_uses_shadow(vector_uses_shadow), .irq(irq));
    ivsm_partner i_partner (.pclk(pclk), .presetn(presetn), .raise(raise),
        .drop(drop), .source(source));
    ////////////////////////////////////////////////////////////////////////
    // Tasks and expectation functions
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            give_verdict();
        end
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // One-cycle condition from the partner
    task automatic pulse(input logic [REQ_COUNT-1:0] m);
        raise <= m;
        @(posedge pclk);
        raise <= '0;
        drop <= m;
        @(posedge pclk);
        drop <= '0;
        repeat (3) @(posedge pclk);
    endtask : pulse
    // Expected {uses shadow, shadow set} for a level
    function automatic logic [3:0] exp_sh(logic [31:0] sw, logic mve,
                                          int lvl);
        logic [3:0] f;
        f = (lvl == 3) ? sw[15:12] : (lvl == 2) ? sw[11:8] : sw[7:4];
        if (!mve) return {sw[0], 3'h0};
        if (f[3]) return 4'h0;
        return {f[2:0] != 3'h0, f[2:0]};
    endfunction : exp_sh
    ////////////////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        #4000000;
        err_count++;
        give_verdict();
    end
    // Main sequence
    initial begin
        void'($urandom(32'hCC932CA1));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, OFS_SHADOW, 0, rd);
        chk("shadow reset", rd, RESET_WORD);
        apb(0, OFS_CONTROL, 0, rd);
        chk("control reset", rd, RESET_WORD);
        for (int i = 0; i < 8; i++) begin
            w = $urandom;
            apb(1, OFS_SHADOW, w, rd);
            apb(0, OFS_SHADOW, 0, rd);
            chk("shadow readback", rd, w & 32'h0000FFF1);
        end
        $display("test registers done");
        pulse(64'h0000_000F_FFF8_0C00);
        apb(0, OFS_FLAG_FOUR, 0, rd);
        chk("flag four", rd, 32'hFFF80C00);
        apb(0, OFS_FLAG_FIVE, 0, rd);
        chk("flag five", rd, 32'h00000003);
        apb(1, OFS_FLAG_FOUR, 32'hFFFFFFFF, rd);
        apb(1, OFS_FLAG_FIVE, 32'h00000003, rd);
        apb(0, OFS_FLAG_FOUR, 0, rd);
        chk("flag four cleared", rd, 32'h0);
        raise <= 64'h4_0000_0000;
        @(posedge pclk);
        raise <= '0;
        repeat (3) @(posedge pclk);
        apb(0, OFS_FLAG_FIVE, 0, rd);
        chk("comparator held", rd, 32'h00000004);
        drop <= 64'h4_0000_0000;
        @(posedge pclk);
        drop <= '0;
        repeat (3) @(posedge pclk);
        apb(0, OFS_FLAG_FIVE, 0, rd);
        chk("comparator gone", rd, 32'h0);
        $display("test flags done");
        apb(1, OFS_ENABLE_FOUR, 32'h00000400, rd);
        apb(1, OFS_MASK, 32'h00000002, rd);
        raise <= 64'h400;
        @(posedge pclk);
        raise <= '0;
        for (int mve = 0; mve < 2; mve++) begin
            apb(1, OFS_CONTROL, 32'(mve) << MULTI_VECTOR_ENABLE_BIT, rd);
            for (int lvl = 1; lvl < 4; lvl++) begin
                sub = 2'($urandom % 4);
                apb(1, OFS_PRIO_BASE + 12'h008,
                    (32'(lvl) << 18) | (32'(sub) << 16), rd);
                for (int k = 0; k < 4; k++) begin
                    w = (k == 0) ? 32'h00007771 :
                        (k == 1) ? 32'h00008880 : $urandom & 32'hFFF1;
                    apb(1, OFS_SHADOW, w, rd);
                    repeat (3) @(posedge pclk);
                    chk("valid", vector_valid, 1'b1);
                    chk("number", vector_number, mve ? 106 : 0);
                    chk("level", vector_level, lvl);
                    chk("sub", vector_sub, sub);
                    chk("shadow", {vector_uses_shadow, vector_shadow_set},
                        exp_sh(w, mve[0], lvl));
                end
            end
        end
        chk("irq raised", irq, 1'b1);
        apb(0, OFS_STATUS, 0, rd);
        chk("event status", rd, 32'h00000003);
        apb(1, OFS_STATUS, 32'h00000003, rd);
        @(posedge pclk);
        chk("irq cleared", irq, 1'b0);
        $display("test vectors done");
        apb(0, 12'hFFC, 0, rd);
        chk("unmapped error", last_err, 1'b1);
        chk("unmapped data", rd, 32'h0);
        $display("test unmapped done");
        give_verdict();
    end
endmodule : interrupt_vector_shadow_map_test
`default_nettype wire
